// >>> hdl/lble_consts.vh
// constants of the ladder bit logic engine
`ifndef LBLE_CONSTS_VH
`define LBLE_CONSTS_VH
`define LBLE_PM_AW         13
`define LBLE_DM_AW         12
`define LBLE_WORD_W        16
`define LBLE_START_ADDR    13'h0000
`define LBLE_STACK_DEPTH   8
`define LBLE_STACK_PW      4
`define LBLE_OPC_MSB       15
`define LBLE_OPC_LSB       12
`define LBLE_NWORDS_MSB    11
`define LBLE_NWORDS_LSB    10
`define LBLE_BIT_MSB       9
`define LBLE_BIT_LSB       0
`define LBLE_OP_NOP        4'h0
`define LBLE_OP_LOAD       4'h1
`define LBLE_OP_LOAD_INV   4'h2
`define LBLE_OP_AND        4'h3
`define LBLE_OP_AND_INV    4'h4
`define LBLE_OP_OR         4'h5
`define LBLE_OP_OR_INV     4'h6
`define LBLE_OP_DRIVE      4'h7
`define LBLE_OP_DRIVE_INV  4'h8
`define LBLE_OP_BLK_AND    4'h9
`define LBLE_OP_BLK_OR     4'ha
`define LBLE_OP_END        4'hf
`endif

// >>> hdl/lble_engine.v
// ladder bit logic execution engine
// Summary of operation
// [RULE_01] one address holds one to four words
// [RULE_02] execution starts at zero, ascends sequentially
// [RULE_03] first word: opcode, definers, lone bit
// [RULE_04] following words are up to three operands
// [RULE_05] load sets condition, inverted load inverts
// [RULE_06] and combines condition with operand bit
// [RULE_07] inverted and uses complemented operand bit
// [RULE_08] or and inverted or combine condition
// [RULE_09] each result feeds the next instruction
// [RULE_10] drive writes condition to operand bit
// [RULE_11] inverted drive writes complemented condition
// [RULE_12] scan stops at terminator; none means idle
// [RULE_13] mid-line load pushes; block ops pop
// [RULE_14] buffer holds eight pending blocks
// [RULE_15] written bits visible later in scan
// [RULE_16] sixteen-bit words, operands fetched sequentially
`include "lble_consts.vh"
// last-in first-out buffer of unused execution conditions
module lble_cond_buffer
#(
   parameter DEPTH = `LBLE_STACK_DEPTH,
   parameter PW    = `LBLE_STACK_PW
)
(
   input  wire   clk_sys_in,
   input  wire   rst_b_in,
   input  wire   clear_in,
   input  wire   push_in,
   input  wire   pop_in,
   input  wire   bit_in,
   output wire   top_out,
   output wire   empty_out,
   output wire   full_out
);
   reg [DEPTH-1:0]  bits_q;
   reg [PW-1:0]     level_q;

   assign top_out   = bits_q[0];
   assign empty_out = (level_q == {PW{1'b0}});
   assign full_out  = (level_q == DEPTH[PW-1:0]);

   // a push when full or a pop when empty leaves the buffer untouched
   always @(posedge clk_sys_in)
   begin
      if (!rst_b_in || clear_in)
      begin
         bits_q  <= {DEPTH{1'b0}};
         level_q <= {PW{1'b0}};
      end
      else if (push_in && !full_out)
      begin
         bits_q  <= {bits_q[DEPTH-2:0], bit_in}; // RULE_13
         level_q <= level_q + 1'b1; // RULE_14
      end
      else if (pop_in && !empty_out)
      begin
         bits_q  <= {1'b0, bits_q[DEPTH-1:1]}; // RULE_13
         level_q <= level_q - 1'b1;
      end
   end
endmodule

module lble_engine
(
   input  wire                          clk_sys_in,
   input  wire                          rst_b_in,
   input  wire                          run_in,
   output reg  [`LBLE_PM_AW-1:0]        pm_addr_out,
   input  wire [`LBLE_WORD_W-1:0]       pm_data_in,
   output reg  [`LBLE_DM_AW-1:0]        dm_addr_out,
   output reg                           dm_rd_out,
   input  wire                          dm_rdata_in,
   output reg                           dm_wr_out,
   output reg                           dm_wdata_out,
   output reg                           cond_out,
   output reg                           scan_done_out,
   output reg                           no_end_out,
   output reg                           stack_err_out
);
   localparam [6:0] ST_CHECK = 7'h01;
   localparam [6:0] ST_FETCH = 7'h02;
   localparam [6:0] ST_DEC   = 7'h04;
   localparam [6:0] ST_OPER  = 7'h08;
   localparam [6:0] ST_READ  = 7'h10;
   localparam [6:0] ST_EXEC  = 7'h20;
   localparam [6:0] ST_IDLE  = 7'h40;

   reg [6:0]                    state_q;
   reg [`LBLE_PM_AW-1:0]        pc_q;
   reg [3:0]                    opc_q;
   reg [1:0]                    left_q;
   reg [`LBLE_DM_AW-1:0]        bit_q;
   reg                          first_q;
   reg                          found_q;
   reg                          opnd;
   reg                          cond_d;
   reg                          buf_push;
   reg                          buf_pop;
   reg                          buf_err;
   wire                         buf_top;
   wire                         buf_empty;
   wire                         buf_full;
   wire                         buf_clear;
   wire [3:0]                   opc_w;

   assign opc_w = pm_data_in[`LBLE_OPC_MSB:`LBLE_OPC_LSB];

   always @*
   begin
      opnd = dm_rdata_in;
   end

   // a terminator empties the buffer for the next scan
   assign buf_clear = (state_q == ST_DEC) && (opc_w == `LBLE_OP_END); // RULE_12

   // pending block conditions
   lble_cond_buffer
   #(
      .DEPTH (`LBLE_STACK_DEPTH),
      .PW    (`LBLE_STACK_PW)
   )
   lble_cond_buffer_inst
   (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .clear_in   (buf_clear),
      .push_in    (buf_push),
      .pop_in     (buf_pop),
      .bit_in     (cond_out),
      .top_out    (buf_top),
      .empty_out  (buf_empty),
      .full_out   (buf_full)
   );

   // next execution condition and buffer requests of the instruction in execution
   always @*
   begin
      cond_d   = cond_out; // RULE_09
      buf_push = 1'b0;
      buf_pop  = 1'b0;
      if (state_q == ST_EXEC)
      begin
         case (opc_q)
            `LBLE_OP_LOAD:
            begin
               cond_d   = opnd; // RULE_05
               buf_push = !first_q; // RULE_13
            end
            `LBLE_OP_LOAD_INV:
            begin
               cond_d   = ~opnd; // RULE_05
               buf_push = !first_q; // RULE_13
            end
            `LBLE_OP_AND:     cond_d = cond_out & opnd; // RULE_06
            `LBLE_OP_AND_INV: cond_d = cond_out & ~opnd; // RULE_07
            `LBLE_OP_OR:      cond_d = cond_out | opnd; // RULE_08
            `LBLE_OP_OR_INV:  cond_d = cond_out | ~opnd; // RULE_08
            `LBLE_OP_BLK_AND:
            begin
               buf_pop = 1'b1;
               if (!buf_empty)
                  cond_d = cond_out & buf_top; // RULE_13
            end
            `LBLE_OP_BLK_OR:
            begin
               buf_pop = 1'b1;
               if (!buf_empty)
                  cond_d = cond_out | buf_top; // RULE_13
            end
            default:
            begin
               cond_d = cond_out;
            end
         endcase
      end
      // refused pop keeps the condition; refused push or pop raises the error
      buf_err = (buf_push && buf_full) || (buf_pop && buf_empty); // RULE_14
   end

   always @(posedge clk_sys_in)
   begin
      if (!rst_b_in)
      begin
         state_q       <= ST_CHECK;
         pc_q          <= `LBLE_START_ADDR;
         pm_addr_out   <= `LBLE_START_ADDR;
         opc_q         <= `LBLE_OP_NOP;
         left_q        <= 2'h0;
         bit_q         <= {`LBLE_DM_AW{1'b0}};
         first_q       <= 1'b1;
         found_q       <= 1'b0;
         dm_addr_out   <= {`LBLE_DM_AW{1'b0}};
         dm_rd_out     <= 1'b0;
         dm_wr_out     <= 1'b0;
         dm_wdata_out  <= 1'b0;
         cond_out      <= 1'b0;
         scan_done_out <= 1'b0;
         no_end_out    <= 1'b0;
         stack_err_out <= 1'b0;
      end
      else
      begin
         dm_rd_out     <= 1'b0;
         dm_wr_out     <= 1'b0;
         scan_done_out <= 1'b0;
         case (state_q)
            // first pass: look for a terminator before running anything
            ST_CHECK:
            begin
               if (opc_w == `LBLE_OP_END)
               begin
                  found_q     <= 1'b1;
                  no_end_out  <= 1'b0;
                  pm_addr_out <= `LBLE_START_ADDR; // RULE_02
                  state_q     <= ST_FETCH;
               end
               else if (pm_addr_out == {`LBLE_PM_AW{1'b1}})
               begin
                  no_end_out  <= 1'b1; // RULE_12
                  state_q     <= ST_IDLE;
               end
               else
                  pm_addr_out <= pm_addr_out + 1'b1;
            end
            ST_IDLE:
            begin
               state_q <= ST_IDLE;
            end
            ST_FETCH:
            begin
               pm_addr_out <= pc_q; // RULE_02
               if (run_in && found_q)
                  state_q <= ST_DEC;
            end
            ST_DEC:
            begin
               opc_q  <= opc_w; // RULE_03
               left_q <= pm_data_in[`LBLE_NWORDS_MSB:`LBLE_NWORDS_LSB]; // RULE_01
               bit_q  <= {2'b00, pm_data_in[`LBLE_BIT_MSB:`LBLE_BIT_LSB]}; // RULE_03
               if (opc_w == `LBLE_OP_END)
               begin
                  pc_q          <= `LBLE_START_ADDR; // RULE_12
                  pm_addr_out   <= `LBLE_START_ADDR;
                  first_q       <= 1'b1;
                  scan_done_out <= 1'b1;
                  state_q       <= ST_FETCH;
               end
               else if (pm_data_in[`LBLE_NWORDS_MSB:`LBLE_NWORDS_LSB] != 2'h0)
               begin
                  pm_addr_out <= pm_addr_out + 1'b1; // RULE_16
                  state_q     <= ST_OPER;
               end
               else
               begin
                  dm_addr_out <= {2'b00, pm_data_in[`LBLE_BIT_MSB:`LBLE_BIT_LSB]};
                  dm_rd_out   <= 1'b1;
                  state_q     <= ST_READ;
               end
            end
            // operand words; the last one names the bit
            ST_OPER:
            begin
               bit_q  <= pm_data_in[`LBLE_DM_AW-1:0]; // RULE_04
               left_q <= left_q - 1'b1;
               if (left_q == 2'h1)
               begin
                  dm_addr_out <= pm_data_in[`LBLE_DM_AW-1:0];
                  dm_rd_out   <= 1'b1;
                  state_q     <= ST_READ;
               end
               else
                  pm_addr_out <= pm_addr_out + 1'b1; // RULE_16
            end
            ST_READ:
            begin
               state_q <= ST_EXEC;
            end
            ST_EXEC:
            begin
               cond_out <= cond_d; // RULE_09
               if (buf_err)
                  stack_err_out <= 1'b1; // RULE_14
               if ((opc_q == `LBLE_OP_LOAD) || (opc_q == `LBLE_OP_LOAD_INV))
                  first_q <= 1'b0;
               if ((opc_q == `LBLE_OP_DRIVE) || (opc_q == `LBLE_OP_DRIVE_INV))
               begin
                  dm_addr_out  <= bit_q;
                  dm_wr_out    <= 1'b1; // RULE_15
                  dm_wdata_out <= (opc_q == `LBLE_OP_DRIVE) ? cond_out : ~cond_out; // RULE_10 RULE_11
                  first_q      <= 1'b1;
               end
               // next instruction starts at the word after the last one used
               pc_q        <= pm_addr_out + 1'b1; // RULE_02
               pm_addr_out <= pm_addr_out + 1'b1;
               state_q     <= ST_FETCH;
            end
            default:
            begin
               state_q <= ST_CHECK;
            end
         endcase
      end
   end
endmodule

// >>> verif/lble_mem_model.sv
// program memory and bit data memory model facing the engine
module lble_mem_model (
   input  wire logic        clk_sys_in,
   input  wire logic [12:0] pm_addr_in,
   output      logic [15:0] pm_data_out,
   input  wire logic [11:0] dm_addr_in,
   input  wire logic        dm_rd_in,
   output      logic        dm_rdata_out,
   input  wire logic        dm_wr_in,
   input  wire logic        dm_wdata_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] pm [0:8191];
   logic        dm [0:4095];
   logic        rd_q = 1'b0;
   logic [1:0]  age_q = 2'h3;
   assign pm_data_out = pm[pm_addr_in];
   // read bit held two cycles after the pulse, inverted after that
   assign dm_rdata_out = age_q[1] ? ~rd_q : rd_q;
   always @(posedge clk_sys_in)
   begin
      if (dm_wr_in)
         dm[dm_addr_in] <= dm_wdata_in;
      if (dm_rd_in)
         rd_q <= dm[dm_addr_in];
      age_q <= dm_rd_in ? 2'h0 : (age_q | {age_q[0], 1'b1});
   end
endmodule

// >>> verif/lble_engine_asserts.sv
// port assertions of the ladder bit logic engine
module lble_engine_asserts (
   input wire logic        clk_sys_in,
   input wire logic        rst_b_in,
   input wire logic [12:0] pm_addr_out,
   input wire logic        dm_rd_out,
   input wire logic        dm_wr_out,
   input wire logic        cond_out,
   input wire logic        scan_done_out,
   input wire logic        no_end_out,
   input wire logic        stack_err_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_b_in);
   property p_addr_step;
      $changed(pm_addr_out) |-> pm_addr_out == $past(pm_addr_out) + 13'h0001 || pm_addr_out == 13'h0000;
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("program address skipped");
   property p_cond_cause;
      $changed(cond_out) |-> $past(dm_rd_out, 2) || $past(dm_rd_out, 3);
   endproperty
   a_cond_cause: assert property (p_cond_cause) else $error("condition changed without read");
   property p_wr_cause;
      dm_wr_out |-> $past(dm_rd_out, 2) || $past(dm_rd_out, 3) || $past(dm_rd_out, 4);
   endproperty
   a_wr_cause: assert property (p_wr_cause) else $error("write without decode");
   property p_rd_pulse;
      dm_rd_out |=> !dm_rd_out;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse too long");
   property p_wr_pulse;
      dm_wr_out |=> !dm_wr_out;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
   property p_restart;
      scan_done_out |-> ##[0:4] pm_addr_out == 13'h0000;
   endproperty
   a_restart: assert property (p_restart) else $error("scan did not restart");
   property p_no_end;
      no_end_out |=> no_end_out && !dm_wr_out && !scan_done_out;
   endproperty
   a_no_end: assert property (p_no_end) else $error("program ran without end");
   property p_err_sticky;
      stack_err_out |=> stack_err_out;
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("buffer error dropped");
   c_done: cover property (scan_done_out);
   c_write: cover property (dm_wr_out);
   c_err: cover property (stack_err_out);
endmodule
bind lble_engine lble_engine_asserts lble_engine_asserts_inst (.clk_sys_in, .rst_b_in, .pm_addr_out, .dm_rd_out,
   .dm_wr_out, .cond_out, .scan_done_out, .no_end_out, .stack_err_out);

// >>> verif/tb_lble_engine.sv
// self-checking testbench of the ladder bit logic engine
module tb_lble_engine;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic        run_in = 1'b0;
   logic [12:0] pm_addr_out;
   logic [15:0] pm_data_in;
   logic [11:0] dm_addr_out;
   logic        dm_rd_out, dm_rdata_in, dm_wr_out, dm_wdata_out, cond_out, scan_done_out, no_end_out, stack_err_out;
   int          fails = 0;
   int          num_checks = 0;
   always #4 clk_sys_in = ~clk_sys_in;
   lble_engine lble_engine_inst (.clk_sys_in, .rst_b_in, .run_in, .pm_addr_out, .pm_data_in, .dm_addr_out,
      .dm_rd_out, .dm_rdata_in, .dm_wr_out, .dm_wdata_out, .cond_out, .scan_done_out, .no_end_out, .stack_err_out);
   lble_mem_model lble_mem_model_inst (.clk_sys_in, .pm_addr_in(pm_addr_out), .pm_data_out(pm_data_in),
      .dm_addr_in(dm_addr_out), .dm_rd_in(dm_rd_out), .dm_rdata_out(dm_rdata_in), .dm_wr_in(dm_wr_out),
      .dm_wdata_in(dm_wdata_out));
   function automatic logic [15:0] w(input logic [3:0] op, input logic [9:0] b);
      return {op, 2'b00, b};
   endfunction
   function automatic logic d(input int a);
      return lble_mem_model_inst.dm[a];
   endfunction
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic exp, input logic got);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
      end
   endtask
   // loads a program, presets bits 0..4 and sets bits 5..107, runs one scan, checks its final condition
   task automatic run_scan(input logic [15:0] p[$], input logic [4:0] b, input logic e);
      int n;
      @(posedge clk_sys_in);
      rst_b_in <= 1'b0;
      run_in <= 1'b0;
      // a write launched before reset lands on the first edge; preset after the second
      repeat (2) @(posedge clk_sys_in);
      for (int i = 0; i < 8192; i++)
         lble_mem_model_inst.pm[i] = (i < p.size()) ? p[i] : 16'h0000;
      for (int i = 0; i < 108; i++)
         lble_mem_model_inst.dm[i] = (i < 5) ? b[i] : 1'b1;
      repeat (5) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      run_in <= 1'b1;
      for (n = 0; n < 10000 && scan_done_out !== 1'b1 && no_end_out !== 1'b1; n++)
         @(negedge clk_sys_in);
      if (n == 10000)
      begin
         fails++;
         stop_test();
      end
      chk("scan_condition", e, cond_out);
      repeat (3) @(posedge clk_sys_in);
   endtask
   task automatic s_logic;
      logic [4:0] b;
      logic       e3;
      logic       e4;
      for (int v = 0; v < 16; v++)
      begin
         b = {v[0] ^ v[3], v[3:0]};
         e3 = (b[0] | b[1]) & (b[2] | ~b[3]);
         e4 = (e3 & ~b[4]) | (b[2] & b[3]);
         run_scan('{w(4'h1, 10'h0), w(4'h3, 10'h1), w(4'h7, 10'h64), w(4'h2, 10'h0), w(4'h6, 10'h1),
            w(4'h8, 10'h65), w(4'h1, 10'h2), w(4'h4, 10'h3), 16'h5400, 16'h0004, w(4'h7, 10'h66),
            w(4'h1, 10'h0), w(4'h5, 10'h1), w(4'h1, 10'h2), w(4'h6, 10'h3), w(4'h9, 10'h0), w(4'h7, 10'h67),
            w(4'h1, 10'h67), w(4'h4, 10'h4), w(4'h1, 10'h2), w(4'h3, 10'h3), w(4'ha, 10'h0), w(4'h7, 10'h68),
            w(4'hf, 10'h0), w(4'h2, 10'h69), w(4'h7, 10'h69)}, b, e4);
         chk("and_drive", b[0] & b[1], d(100));
         chk("inv_or_inv_drive", b[0] & b[1], d(101));
         chk("and_inv_or_operand", (b[2] & ~b[3]) | b[4], d(102));
         chk("block_conjunction", e3, d(103));
         chk("block_disjunction", (e3 & ~b[4]) | (b[2] & b[3]), d(104));
         chk("after_end", 1'b1, d(105));
      end
   endtask
   task automatic s_blocks;
      logic [15:0] p[$];
      p.push_back(w(4'h1, 10'h1));
      for (int i = 0; i < 14; i++)
         p.push_back(w((i < 7) ? 4'h1 : 4'h9, 10'h0));
      p.push_back(w(4'h7, 10'h6b));
      p.push_back(w(4'hf, 10'h0));
      run_scan(p, 5'h01, 1'b0);
      chk("eight_blocks", 1'b0, d(107));
      chk("no_buffer_err", 1'b0, stack_err_out);
      // nop, two and three operand words, then a block op on an empty buffer
      run_scan('{w(4'h1, 10'h0), w(4'h0, 10'h0), 16'h4800, 16'h0000, 16'h0001, 16'h3c00, 16'h0001, 16'h0001,
         16'h0000, w(4'ha, 10'h0), w(4'h8, 10'h6a), w(4'hf, 10'h0)}, 5'h01, 1'b1);
      chk("underflow_err", 1'b1, stack_err_out);
      chk("multi_word_operands", 1'b0, d(106));
   endtask
   task automatic s_no_end;
      run_scan('{w(4'h2, 10'h0), w(4'h7, 10'h64)}, 5'h01, 1'b0);
      chk("no_end", 1'b1, no_end_out);
      chk("not_executed", 1'b1, d(100));
   endtask
   initial
   begin
      s_logic();
      s_blocks();
      s_no_end();
      stop_test();
   end
endmodule
